// ==== axis_motion_parameter_regs.sv ====
// Purpose: per-axis speed, ramp, sync, limit and property registers
// Assumes: motion core supplies status levels synchronous to aclk
// Notes:   instruction-loaded registers change only via the order reg
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`include "axis_motion_defines.svh"

// How it works
// - speed bounds are 14 bits, upper zero
// - floor write blocked running with decel-stop
// - start command checks speeds, clamps or aborts
// - ramp register: up low, down high
// - ramp format bit picks rate or time
// - ramp write blocked running with decel-stop
// - start command validates ramps, fixes or errors
// - sync command bits 19-16, ready at 14
// - other sync fields mirror axis status
// - motion state: direction plus phase code
// - sensor summary set when any sensor high
// - trigger byte low, 9-bit address above
// - trigger loaded by instruction when stopped
// - limits signed 24-bit, loaded when stopped
// - limits used only when enabled, source select
// - watchdog span bits 23-16, zero disables
// - velocity band select bits 15-14
// - curve bit 12, others reserved zero
// - peak hold bits 9-0, zero disables
// - property one loaded by instruction when stopped
// - property one resets to 0x009000
// - property two bit 13 selects ramp format
// - property two bit 23 enables autofix
module axis_motion_parameter_regs
  import axis_motion_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        axis_running,
  input  wire logic [2:0]  motion_state_bits,
  input  wire logic        all_stop_flag,
  input  wire logic        sync_prep_done,
  input  wire logic [3:0]  position_sensor_inputs,
  input  wire logic [4:0]  pattern_index,
  input  wire logic [3:0]  output_monitor,
  input  wire logic [3:0]  input_monitor,
  output logic [3:0]       sync_cmd,
  output logic             sync_cmd_strobe,
  output logic             axis_start,
  output logic             axis_check_error,
  output logic             ramp_format_select,
  output logic             trigger_active,
  output logic [7:0]       sync_trigger_value,
  output logic [8:0]       sync_trigger_gm_addr,
  output logic             limit_active,
  output logic             limit_compare_source,
  output logic [23:0]      upper_limit_out,
  output logic [23:0]      lower_limit_out,
  output logic [7:0]       output_watchdog_span,
  output logic [1:0]       velocity_band_select,
  output logic             s_curve_select,
  output logic [9:0]       peak_hold_time,
  output logic             position_sensor_any
);

  // storage
  logic [13:0] speed_floor;
  logic [13:0] speed_ceiling;
  word24_t     speed_ramp_rates;
  word24_t     sync_trigger_setup;
  word24_t     upper_limit_coord;
  word24_t     lower_limit_coord;
  word24_t     property_group_one;
  word24_t     property_group_two;
  word24_t     write_staging_reg;
  logic [2:0]  check_status;
  logic [3:0]  sync_cmd_q;

  // bus bookkeeping
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic        wr_hit;
  logic [31:0] wmask;
  logic [31:0] merged;
  logic        stop_kind_select;
  logic        param_autofix;
  logic        ord_write;
  order_code_e ord_code;
  logic        load_ok;

  // range check
  logic [11:0] up_rate;
  logic [11:0] dn_rate;
  logic        speed_bad;
  logic        ramp_bad;
  logic [13:0] fixed_floor;
  logic [13:0] fixed_ceiling;
  logic [11:0] fixed_up;
  logic [11:0] fixed_dn;
  logic        start_req;

  // address decode shared by read and write paths
  function automatic logic reg_mapped(input logic [7:0] a);
    reg_mapped = (a[1:0] == 2'h0) && (a <= `OFS_CHECK_STAT);
  endfunction

  // strobe to bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  assign stop_kind_select   = property_group_two[`PG2_STOPK_BIT];
  assign param_autofix      = property_group_two[`PG2_PAC_BIT];
  assign ramp_format_select = property_group_two[`PG2_RAMP_FORMAT_SELECT_BIT];

  // write channel handshakes; no new beat while response pending
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
  assign wr_hit        = wr_fire && reg_mapped(aw_addr);
  assign wmask         = strb_mask(w_strb);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // write response one cycle after both beats are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= reg_mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // merge of strobed bytes with the old word, selected per target
  always_comb begin
    merged = 32'h0000_0000;
    unique case (aw_addr)
      `OFS_SPEED_FLOOR:   merged = {18'h0, speed_floor};
      `OFS_SPEED_CEILING: merged = {18'h0, speed_ceiling};
      `OFS_RAMP_RATES:    merged = {8'h00, speed_ramp_rates};
      `OFS_PROP_TWO:      merged = {8'h00, property_group_two};
      `OFS_STAGING:       merged = {8'h00, write_staging_reg};
      default:            merged = 32'h0000_0000;
    endcase
    merged = (merged & ~wmask) | (w_data & wmask);
  end

  // instruction path: only byte 0 carries the order code
  assign ord_write = wr_hit && (aw_addr == `OFS_ORDER) && w_strb[0];
  assign ord_code  = order_code_e'(w_data[3:0]);
  assign load_ok   = !axis_running;
  assign start_req = ord_write && (ord_code == ORD_AXIS_START);

  // parameter range check evaluated at the start instruction
  assign up_rate   = speed_ramp_rates[`RAMP_UP_LSB +: 12];
  assign dn_rate   = speed_ramp_rates[`RAMP_DN_LSB +: 12];
  assign speed_bad = (speed_floor == 14'h0000) ||
                     (speed_ceiling == 14'h0000) ||
                     (speed_floor > speed_ceiling);
  assign ramp_bad  = (up_rate == 12'h000) || (dn_rate == 12'h000);

  // clamp harmful values into the nearest legal setting
  always_comb begin
    fixed_ceiling = speed_ceiling;
    fixed_floor   = speed_floor;
    fixed_up      = up_rate;
    fixed_dn      = dn_rate;
    if (fixed_ceiling == 14'h0000) begin
      fixed_ceiling = 14'h0001;
    end
    if (fixed_floor == 14'h0000) begin
      fixed_floor = 14'h0001;
    end
    if (fixed_floor > fixed_ceiling) begin
      fixed_floor = fixed_ceiling; // zero-width transition is legal
    end
    if (fixed_up == 12'h000) begin
      fixed_up = 12'h001;
    end
    if (fixed_dn == 12'h000) begin
      fixed_dn = 12'h001;
    end
  end

  // speed floor: blocked while a decel stop may need it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      speed_floor <= 14'h0000;
    end else if (start_req && speed_bad && param_autofix) begin
      speed_floor <= fixed_floor;
    end else if (wr_hit && aw_addr == `OFS_SPEED_FLOOR &&
                 !(axis_running && stop_kind_select)) begin
      speed_floor <= merged[`SPEED_W-1:0];
    end
  end

  // speed ceiling: writable at any time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      speed_ceiling <= 14'h0000;
    end else if (start_req && speed_bad && param_autofix) begin
      speed_ceiling <= fixed_ceiling;
    end else if (wr_hit && aw_addr == `OFS_SPEED_CEILING) begin
      speed_ceiling <= merged[`SPEED_W-1:0];
    end
  end

  // ramp rates: same protection as the floor
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      speed_ramp_rates <= 24'h000000;
    end else if (start_req && ramp_bad && param_autofix) begin
      speed_ramp_rates <= {fixed_dn, fixed_up};
    end else if (wr_hit && aw_addr == `OFS_RAMP_RATES &&
                 !(axis_running && stop_kind_select)) begin
      speed_ramp_rates <= merged[23:0];
    end
  end

  // start outcome: go, or abort with error when autofix is off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      axis_start       <= 1'b0;
      axis_check_error <= 1'b0;
    end else begin
      axis_start       <= start_req &&
                          (param_autofix || !(speed_bad || ramp_bad));
      axis_check_error <= start_req && !param_autofix &&
                          (speed_bad || ramp_bad);
    end
  end

  // sticky check status: bit0 error, bit1 corrected, bit2 load refused
  // write one clears; a new event in the same cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      check_status <= 3'h0;
    end else begin
      check_status <= (check_status &
                       ~((wr_hit && aw_addr == `OFS_CHECK_STAT) ?
                         (w_data[2:0] & {3{w_strb[0]}}) : 3'h0)) |
                      {ord_write && !load_ok && ord_code != ORD_NONE &&
                       ord_code != ORD_AXIS_START,
                       start_req && param_autofix &&
                       (speed_bad || ramp_bad),
                       start_req && !param_autofix &&
                       (speed_bad || ramp_bad)};
    end
  end

  // software-writable property two and staging register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      property_group_two <= `PG2_RESET;
      write_staging_reg  <= 24'h000000;
    end else if (wr_hit && aw_addr == `OFS_PROP_TWO) begin
      property_group_two <= merged[23:0] & `PG2_MASK;
    end else if (wr_hit && aw_addr == `OFS_STAGING) begin
      write_staging_reg <= merged[23:0];
    end
  end

  // instruction-loaded registers copy staging only while stopped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_trigger_setup <= 24'h000000;
      upper_limit_coord  <= 24'h000000;
      lower_limit_coord  <= 24'h000000;
      property_group_one <= `PG1_RESET;
    end else if (ord_write && load_ok) begin
      unique case (ord_code)
        ORD_TRIG_LOAD: sync_trigger_setup <=
          {7'h00, write_staging_reg[`TRIG_W-1:0]};
        ORD_UPPER_LOAD: upper_limit_coord <= write_staging_reg;
        ORD_LOWER_LOAD: lower_limit_coord <= write_staging_reg;
        ORD_PROP1_LOAD: property_group_one <=
          write_staging_reg & `PG1_MASK;
        default: ;
      endcase
    end
  end

  // sync command bits and a strobe on each write to the sync register that strobes byte 2
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_cmd_q      <= 4'h0;
      sync_cmd_strobe <= 1'b0;
    end else begin
      sync_cmd_strobe <= 1'b0;
      if (wr_hit && aw_addr == `OFS_SYNC_CMD_STAT && w_strb[2]) begin
        sync_cmd_q      <= w_data[`SYNC_CMD_LSB +: 4];
        sync_cmd_strobe <= 1'b1;
      end
    end
  end
  assign sync_cmd = sync_cmd_q;

  // field outputs straight from the stored words; the sensor summary comes straight from the inputs
  assign position_sensor_any  = |position_sensor_inputs;
  assign trigger_active       =
    !property_group_two[`PG2_SYNC_SOURCE_SELECT_BIT];
  assign sync_trigger_value   = sync_trigger_setup[7:0];
  assign sync_trigger_gm_addr = sync_trigger_setup[16:8];
  assign limit_active         = property_group_two[`PG2_LCE_BIT];
  assign limit_compare_source =
    property_group_two[`PG2_LIMIT_COMPARE_SOURCE_BIT];
  assign upper_limit_out      = upper_limit_coord;
  assign lower_limit_out      = lower_limit_coord;
  assign output_watchdog_span =
    property_group_one[`PG1_WDOG_LSB +: 8];
  assign velocity_band_select =
    property_group_one[`PG1_SRS_LSB +: 2];
  assign s_curve_select       = property_group_one[`PG1_CS_BIT];
  assign peak_hold_time       = property_group_one[9:0];

  // read channel: one outstanding read, data one cycle after address
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= reg_mapped(s_axi_araddr) ? `RESP_OKAY
                                               : `RESP_SLVERR;
      unique case (s_axi_araddr)
        `OFS_SPEED_FLOOR:   s_axi_rdata <= {18'h0, speed_floor};
        `OFS_SPEED_CEILING: s_axi_rdata <= {18'h0, speed_ceiling};
        `OFS_RAMP_RATES:    s_axi_rdata <= {8'h00, speed_ramp_rates};
        `OFS_SYNC_CMD_STAT: s_axi_rdata <= {8'h00,
          motion_state_bits, 1'b0, sync_cmd_q,
          all_stop_flag, sync_prep_done,
          |position_sensor_inputs, pattern_index,
          output_monitor, input_monitor};
        `OFS_SYNC_TRIG:     s_axi_rdata <= {8'h00, sync_trigger_setup};
        `OFS_UPPER_LIMIT:   s_axi_rdata <= {8'h00, upper_limit_coord};
        `OFS_LOWER_LIMIT:   s_axi_rdata <= {8'h00, lower_limit_coord};
        `OFS_PROP_ONE:      s_axi_rdata <= {8'h00, property_group_one};
        `OFS_PROP_TWO:      s_axi_rdata <= {8'h00, property_group_two};
        `OFS_STAGING:       s_axi_rdata <= {8'h00, write_staging_reg};
        `OFS_CHECK_STAT:    s_axi_rdata <= {29'h0, check_status};
        default:            s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ==== axis_motion_defines.svh ====
// Purpose: offsets, field positions and reset values of the axis
//          parameter register bank
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes:   definitions only
`ifndef AXIS_MOTION_DEFINES_SVH
`define AXIS_MOTION_DEFINES_SVH

// register byte offsets
`define OFS_SPEED_FLOOR    8'h00
`define OFS_SPEED_CEILING  8'h04
`define OFS_RAMP_RATES     8'h08
`define OFS_SYNC_CMD_STAT  8'h0C
`define OFS_SYNC_TRIG      8'h10
`define OFS_UPPER_LIMIT    8'h14
`define OFS_LOWER_LIMIT    8'h18
`define OFS_PROP_ONE       8'h1C
`define OFS_PROP_TWO       8'h20
`define OFS_STAGING        8'h24
`define OFS_ORDER          8'h28
`define OFS_CHECK_STAT     8'h2C

// field positions
`define SPEED_W            14
`define RAMP_UP_LSB        0
`define RAMP_DN_LSB        12
`define SYNC_CMD_LSB       16
`define SYNC_READY_BIT     14
`define TRIG_W             17
`define PG1_CS_BIT         12
`define PG1_SRS_LSB        14
`define PG1_WDOG_LSB       16
`define PG1_MASK           24'hFFD3FF
`define PG2_LCE_BIT        8
`define PG2_LIMIT_COMPARE_SOURCE_BIT     9
`define PG2_RAMP_FORMAT_SELECT_BIT       13
`define PG2_SYNC_SOURCE_SELECT_BIT      14
`define PG2_STOPK_BIT      15
`define PG2_PAC_BIT        23
`define PG2_MASK           24'hFFFF3F

// reset values
`define PG1_RESET          24'h009000
`define PG2_RESET          24'h000000

// axi responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ==== axis_motion_pkg.sv ====
// Purpose: types shared by the axis parameter register bank
// Assumes: nothing
// Notes:   offsets live in axis_motion_defines.svh
package axis_motion_pkg;
  typedef logic [23:0] word24_t;
  typedef enum logic [3:0] {
    ORD_NONE       = 4'h0,
    ORD_AXIS_START = 4'h1,
    ORD_TRIG_LOAD  = 4'h2,
    ORD_UPPER_LOAD = 4'h3,
    ORD_LOWER_LOAD = 4'h4,
    ORD_PROP1_LOAD = 4'h5
  } order_code_e;
endpackage

// ==== axis_regs_monitor.sv ====
// Purpose: port-level checks on the axis parameter register bank
// Assumes: one clock, synchronous active-low reset
// Notes:   read checks key off the last accepted read address
module axis_regs_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        axis_running,
  input wire logic        axis_start,
  input wire logic        axis_check_error,
  input wire logic        sync_cmd_strobe,
  input wire logic [23:0] upper_limit_out,
  input wire logic [23:0] lower_limit_out,
  input wire logic [7:0]  output_watchdog_span,
  input wire logic [1:0]  velocity_band_select,
  input wire logic        s_curve_select,
  input wire logic [9:0]  peak_hold_time,
  input wire logic [3:0]  position_sensor_inputs,
  input wire logic        position_sensor_any
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rd_addr;

  // rdata is registered, so remember which register the read targets
  always_ff @(posedge aclk) begin
    if (!aresetn)
      rd_addr <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready)
      rd_addr <= s_axi_araddr;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // reserved bits of the speed, sync, trigger and property one registers read back as zero
  chk_speed_pad: assert property (s_axi_rvalid && rd_addr[7:3] == 5'h00
    |-> s_axi_rdata[31:14] == 18'h0) else $error("speed bound pad set");
  chk_sync_pad: assert property (s_axi_rvalid && rd_addr == 8'h0C
    |-> s_axi_rdata[31:24] == 8'h0 && !s_axi_rdata[20])
    else $error("sync word pad set");
  chk_trig_pad: assert property (s_axi_rvalid && rd_addr == 8'h10
    |-> s_axi_rdata[31:17] == 15'h0) else $error("trigger pad set");
  chk_prop_pad: assert property (s_axi_rvalid && rd_addr == 8'h1C
    |-> s_axi_rdata[31:24] == 8'h0 && !s_axi_rdata[13]
    && s_axi_rdata[11:10] == 2'h0) else $error("property pad set");
  chk_sensor_or: assert property (
    position_sensor_any == |position_sensor_inputs)
    else $error("sensor summary wrong");
  // reset value must hold even though reset disables the rest
  chk_prop_reset: assert property (disable iff (1'b0) !aresetn
    |=> s_curve_select && velocity_band_select == 2'h2
    && output_watchdog_span == 8'h00 && peak_hold_time == 10'h000)
    else $error("property one reset value wrong");
  // loaded registers cannot move while the axis keeps running
  chk_limit_hold: assert property (
    axis_running && $past(axis_running) && $past(aresetn)
    |-> $stable(upper_limit_out) && $stable(lower_limit_out))
    else $error("limit changed while running");
  chk_prop_hold: assert property (
    axis_running && $past(axis_running) && $past(aresetn)
    |-> $stable(peak_hold_time) && $stable(output_watchdog_span))
    else $error("property one changed while running");
  chk_start_once: assert property (axis_start
    |-> !axis_check_error ##1 !axis_start) else $error("start pulse bad");

  cover property (axis_start);
  cover property (axis_check_error);
  cover property (sync_cmd_strobe);
endmodule

bind axis_motion_parameter_regs axis_regs_monitor mon (.*);

// ==== tb.sv ====
// Purpose: self-checking bench for axis_motion_parameter_regs
// Assumes: bready, rready and wstrb held fixed by the master
// Notes:   outputs are judged at the falling edge after a transfer
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, axis_running;
  logic        all_stop_flag, sync_prep_done, sync_cmd_strobe, axis_start;
  logic        axis_check_error, ramp_format_select, trigger_active;
  logic        limit_active, limit_compare_source, s_curve_select;
  logic        position_sensor_any, got_start, got_err, got_sync;
  logic [1:0]  wr_resp;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, sync_trigger_value;
  logic [7:0]  output_watchdog_span;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0]  s_axi_wstrb, position_sensor_inputs, output_monitor;
  logic [3:0]  input_monitor, sync_cmd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_resp, velocity_band_select;
  logic [2:0]  motion_state_bits;
  logic [4:0]  pattern_index;
  logic [8:0]  sync_trigger_gm_addr;
  logic [23:0] upper_limit_out, lower_limit_out;
  logic [9:0]  peak_hold_time;
  int          miscompares, samples_checked;

  axis_motion_parameter_regs dut (.*);

  // 40 MHz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic hang();
    miscompares++;
    $display("wrong value at %0t: no bus answer", $time);
    end_sim();
  endtask

  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 40);
    if (s_axi_bvalid !== 1'b1) hang();
    // pulses launched with bvalid still stand at this edge
    got_start = axis_start;
    got_err = axis_check_error;
    got_sync = sync_cmd_strobe;
    wr_resp = s_axi_bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 40);
    if (s_axi_rvalid !== 1'b1) hang();
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rd_data, exp);
  endtask

  // reset values, widths, unmapped address
  task automatic t_plain();
    rdc(8'h1C, 32'h00009000);
    wr(8'h00, 32'hFFFFFFFF);
    rdc(8'h00, 32'h00003FFF);
    wr(8'h04, 32'h0000C123);
    rdc(8'h04, 32'h00000123);
    wr(8'h08, 32'hFFABC123);
    rdc(8'h08, 32'h00ABC123);
    rd(8'h30);
    chk({30'h0, rd_resp}, 32'h2);
    wr(8'h30, 32'h00000000);
    chk({30'h0, wr_resp}, 32'h2);
  endtask

  // floor and ramp locked only when running with decel-stop chosen
  task automatic t_protect();
    wr(8'h20, 32'h00008000);
    axis_running <= 1'b1;
    wr(8'h00, 32'h00000011);
    rdc(8'h00, 32'h00003FFF);
    wr(8'h08, 32'h00000111);
    rdc(8'h08, 32'h00ABC123);
    wr(8'h20, 32'h00000000);
    wr(8'h08, 32'h00000444);
    rdc(8'h08, 32'h00000444);
    axis_running <= 1'b0;
  endtask

  // sync command and the status mirrors, every motion state code
  task automatic t_mirror();
    wr(8'h0C, 32'h000F0000);
    chk({31'h0, got_sync}, 32'h1);
    @(negedge aclk);
    chk({28'h0, sync_cmd}, 32'hF);
    for (int i = 0; i < 8; i++) begin
      @(posedge aclk);
      motion_state_bits <= i[2:0];
      position_sensor_inputs <= {1'b0, i[2:0]};
      rd(8'h0C);
      chk(rd_data & 32'hFFF0FFFF,
          {8'h00, i[2:0], 5'h00, 2'h3, i != 0, 5'h15, 8'hA5});
      @(negedge aclk);
      chk({31'h0, position_sensor_any}, {31'h0, i != 0});
    end
  endtask

  // instruction loads from staging, then refused while running
  task automatic t_loads();
    wr(8'h24, 32'hFFFFFFFF);
    wr(8'h28, 32'h00000002);
    rdc(8'h10, 32'h0001FFFF);
    wr(8'h28, 32'h00000005);
    rdc(8'h1C, 32'h00FFD3FF);
    chk({11'h0, output_watchdog_span, velocity_band_select, s_curve_select,
         peak_hold_time}, 32'h001FFFFF);
    wr(8'h24, 32'h00800000);
    wr(8'h28, 32'h00000003);
    wr(8'h24, 32'h00004000);
    wr(8'h28, 32'h00000004);
    wr(8'h28, 32'h00000005);
    rdc(8'h14, 32'h00800000);
    rdc(8'h18, 32'h00004000);
    chk({8'h00, lower_limit_out}, 32'h00004000);
    axis_running <= 1'b1;
    wr(8'h24, 32'h00000123);
    wr(8'h28, 32'h00000003);
    wr(8'h28, 32'h00000002);
    wr(8'h14, 32'h00000000);
    rdc(8'h14, 32'h00800000);
    rdc(8'h10, 32'h0001FFFF);
    @(negedge aclk);
    chk({4'h0, sync_trigger_gm_addr, sync_trigger_value, upper_limit_out[23:16],
         velocity_band_select, s_curve_select}, 32'h0FFFFC02);
    @(posedge aclk);
    axis_running <= 1'b0;
    wr(8'h20, 32'h00002300);
    @(negedge aclk);
    chk({ramp_format_select, limit_active, limit_compare_source,
         trigger_active}, 4'hF);
    wr(8'h20, 32'h00004000);
    @(negedge aclk);
    chk({limit_active, trigger_active}, 2'h0);
  endtask

  // start command: abort without autofix, clamp and run with it
  task automatic t_start();
    wr(8'h00, 32'h0000000A);
    wr(8'h04, 32'h00000005);
    wr(8'h08, 32'h00001001);
    for (int k = 0; k < 4; k++) begin
      if (k == 2) wr(8'h08, 32'h00000000);
      wr(8'h20, k[0] ? 32'h00800000 : 32'h00000000);
      wr(8'h28, 32'h00000001);
      chk({got_start, got_err}, k[0] ? 2'h2 : 2'h1);
    end
    rdc(8'h00, 32'h00000005);
    rdc(8'h08, 32'h00001001);
    // sticky outcomes: abort, correction and the refused loads
    rdc(8'h2C, 32'h00000007);
    wr(8'h2C, 32'h00000007);
    rdc(8'h2C, 32'h00000000);
  endtask

  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, axis_running} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
    {all_stop_flag, sync_prep_done, pattern_index} = 7'h75;
    {output_monitor, input_monitor} = 8'hA5;
    {motion_state_bits, position_sensor_inputs} = 7'h00;
    miscompares = 0;
    samples_checked = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_plain();
    t_protect();
    t_mirror();
    t_loads();
    t_start();
    end_sim();
  end
endmodule
